// ===== pkg/cdfs_defines.svh
// register offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef CDFS_DEFINES_SVH
`define CDFS_DEFINES_SVH
`define CDFS_OFS_STATUS     8'h00
`define CDFS_OFS_ENTRY      8'h04
`define CDFS_OFS_PROT       8'h08
`define CDFS_OFS_SADDR      8'h0C
`define CDFS_OFS_EADDR      8'h10
`define CDFS_OFS_BCCTL      8'h14
`define CDFS_OFS_BCSTAT     8'h18
`define CDFS_OFS_PSADDR     8'h1C
`define CDFS_OFS_CLKNOTE    8'h20
`define CDFS_OFS_AVSTAT     8'h24
`define CDFS_OFS_AVIRQ      8'h28
`define CDFS_OFS_CMD        8'h2C
`define CDFS_OFS_UID0       8'h30
`define CDFS_OFS_UID1       8'h34
`define CDFS_OFS_UID2       8'h38
`define CDFS_OFS_UNC_ADDR0  8'h40
`define CDFS_OFS_UNC_ADDR1  8'h44
`define CDFS_OFS_UNC_SET0   8'h48
`define CDFS_OFS_UNC_SET1   8'h4C
`define CDFS_OFS_WDATA      8'h50
`define CDFS_BIT_PSUSP      8
`define CDFS_BIT_ESUSP      9
`define CDFS_BIT_BUF_FULL   10
`define CDFS_BIT_SUSP_RDY   11
`define CDFS_BIT_PERR       12
`define CDFS_BIT_EERR       13
`define CDFS_BIT_ILGL       14
`define CDFS_BIT_RDY        15
`define CDFS_BIT_WEPERR     7
`define CDFS_KEY_ENTRY      8'hAA
`define CDFS_KEY_PROT       8'h55
`define CDFS_KEY_CLK        8'h1E
`define CDFS_CODE_PROG_BYTES 256
`define CDFS_DATA_PROG_BYTES 4
`define CDFS_BLOCK_MASK     32'h0000_0FFF
`define CDFS_BC_MAX_BYTES   32'h0000_8000
`define CDFS_CODE_BASE      32'hFF00_0000
`define CDFS_DATA_BASE      32'h0010_0000
`define CDFS_DATA_TOP       32'h0010_7FFF
`define CDFS_CLK_RST        8'h3C
`define CDFS_OP_US          2
`define CDFS_CLK_MHZ        100
`define CDFS_OP_CYC         ((`CDFS_OP_US * `CDFS_CLK_MHZ) < 1 ? 1 : (`CDFS_OP_US * `CDFS_CLK_MHZ))
`endif

// ===== pkg/cdfs_pkg.sv
// types shared by the flash sequencer modules
package cdfs_pkg;
  typedef enum logic [2:0] {
    CDFS_IDLE  = 3'b000,
    CDFS_RUN   = 3'b001,
    CDFS_FILL  = 3'b011,
    CDFS_DONE  = 3'b010
  } cdfs_state_e;
  typedef enum logic [3:0] {
    CDFS_CMD_NONE  = 4'h0,
    CDFS_CMD_PROG  = 4'h1,
    CDFS_CMD_ERASE = 4'h2,
    CDFS_CMD_BLANK = 4'h3
  } cdfs_cmd_e;
  typedef logic [31:0] cdfs_word_t;
endpackage : cdfs_pkg

// ===== pkg/cdfs_op_if.sv
// interface between register front end and operation engine
`timescale 1ns/1ps
interface cdfs_op_if;
  logic start;
  cdfs_pkg::cdfs_cmd_e cmd;
  logic is_data;
  logic [31:0] saddr;
  logic [31:0] eaddr;
  logic busy;
  logic done;
  logic blank;
  logic fail;
  modport front (output start, output cmd, output is_data, output saddr, output eaddr,
                 input busy, input done, input blank, input fail);
  modport engine (input start, input cmd, input is_data, input saddr, input eaddr,
                  output busy, output done, output blank, output fail);
endinterface : cdfs_op_if

// ===== src/cdfs_engine.sv
// operation engine: walks the command range in program or erase units
`timescale 1ns/1ps
`include "cdfs_defines.svh"
module cdfs_engine #(
  parameter int OP_CYC = `CDFS_OP_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // array status
  input wire logic i_cell_erased,
  // link to front end
  cdfs_op_if.engine op
);
  import cdfs_pkg::*;
  typedef struct packed {
    cdfs_state_e st;
    logic [31:0] addr;
    logic [15:0] tmr;
    logic blank;
    logic done;
  } cdfs_eng_s;
  cdfs_eng_s q, d;

  function automatic logic [31:0] unit_bytes(input cdfs_cmd_e c, input logic dat);
    if (c == CDFS_CMD_ERASE)
      unit_bytes = `CDFS_BLOCK_MASK + 32'h1;
    else if (dat)
      unit_bytes = 32'(`CDFS_DATA_PROG_BYTES);
    else
      unit_bytes = 32'(`CDFS_CODE_PROG_BYTES);
  endfunction : unit_bytes

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      CDFS_IDLE:
      begin
        if (op.start)
        begin
          d.st = CDFS_RUN;
          d.addr = op.saddr;
          d.tmr = 16'(OP_CYC);
          d.blank = 1'b1;
        end
      end
      CDFS_RUN:
      begin
        if (op.cmd == CDFS_CMD_BLANK && !i_cell_erased)
          d.blank = 1'b0;
        if (q.tmr > 16'h1)
          d.tmr = q.tmr - 16'h1;
        else
          d.st = CDFS_FILL;
      end
      CDFS_FILL:
      begin
        if (q.addr + unit_bytes(op.cmd, op.is_data) > op.eaddr)
          d.st = CDFS_DONE;
        else
        begin
          d.addr = q.addr + unit_bytes(op.cmd, op.is_data);
          d.tmr = 16'(OP_CYC);
          d.st = CDFS_RUN;
        end
      end
      CDFS_DONE:
      begin
        d.done = 1'b1;
        d.st = CDFS_IDLE;
      end
      default: d.st = CDFS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign op.busy = (q.st != CDFS_IDLE);
  assign op.done = q.done;
  assign op.blank = q.blank;
  assign op.fail = 1'b0;
endmodule : cdfs_engine

// ===== src/cdfs_top.sv
// flash sequencer register front end, command checks and status
`timescale 1ns/1ps
`include "cdfs_defines.svh"
module cdfs_top #(
  parameter logic [31:0] UID0 = 32'h1234_5678, // arbitrary value
  parameter logic [31:0] UID1 = 32'h9ABC_DEF0, // arbitrary value
  parameter logic [31:0] UID2 = 32'h0F1E_2D3C, // arbitrary value
  parameter int OP_CYC = `CDFS_OP_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire cdfs_pkg::cdfs_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output cdfs_pkg::cdfs_word_t o_rdata,
  // flash array side
  input wire logic i_cell_erased,
  input wire logic i_code_bad_access,
  input wire logic i_data_bad_access,
  // status out
  output logic o_access_irq,
  output logic o_busy
);
  import cdfs_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] saddr;
    logic [31:0] eaddr;
    logic [31:0] psaddr;
    logic [31:0] rdata;
    logic [31:0] unc_addr0;
    logic [31:0] unc_addr1;
    logic [31:0] unc_set0;
    logic [31:0] unc_set1;
    logic [7:0] clk_mhz;
    logic code_pe;
    logic data_pe;
    logic prot_off;
    logic bc_on;
    logic bc_res;
    logic psusp;
    logic esusp;
    logic buf_full;
    logic perr;
    logic eerr;
    logic ilgl;
    logic weperr;
    logic cav;
    logic dav;
    logic cav_ie;
    logic dav_ie;
    logic run;
    logic start;
    cdfs_cmd_e cmd;
    logic irq;
  } cdfs_top_s;
  cdfs_top_s q, d;

  cdfs_op_if op ();

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = i_wr && (i_addr == ofs);
  endfunction : wr_at

  function automatic logic in_data(input logic [31:0] a);
    in_data = (a >= `CDFS_DATA_BASE) && (a <= `CDFS_DATA_TOP);
  endfunction : in_data

  // ------------------------------------------------------------
  // command checking
  // ------------------------------------------------------------
  logic [31:0] span;
  logic is_dat;
  logic cmd_ok;
  cdfs_cmd_e new_cmd;
  always_comb
  begin
    span = q.eaddr - q.saddr + 32'h1;
    is_dat = in_data(q.saddr);
    new_cmd = cdfs_cmd_e'(i_wdata[3:0]);
    cmd_ok = 1'b1;
    case (new_cmd)
      CDFS_CMD_PROG:
      begin
        // a partial last unit would run past the end address
        if (is_dat)
          cmd_ok = q.data_pe && (q.saddr[1:0] == 2'h0) && (span[1:0] == 2'h0);
        else
          cmd_ok = q.code_pe && (q.saddr[7:0] == 8'h00) && (span[7:0] == 8'h00);
      end
      CDFS_CMD_ERASE:
        cmd_ok = (is_dat ? q.data_pe : q.code_pe)
                 && ((q.saddr & `CDFS_BLOCK_MASK) == 32'h0)
                 && ((span & `CDFS_BLOCK_MASK) == 32'h0);
      CDFS_CMD_BLANK:
        cmd_ok = is_dat && q.data_pe && (span[1:0] == 2'h0)
                 && (span >= 32'h4) && (span <= `CDFS_BC_MAX_BYTES);
      default: cmd_ok = 1'b0;
    endcase
    if (q.eaddr < q.saddr)
      cmd_ok = 1'b0;
  end

  // ------------------------------------------------------------
  // register and status update
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.start = 1'b0;
    if (wr_at(`CDFS_OFS_SADDR))
      d.saddr = i_wdata;
    if (wr_at(`CDFS_OFS_EADDR))
      d.eaddr = i_wdata;
    if (wr_at(`CDFS_OFS_PSADDR))
      d.psaddr = i_wdata;
    if (wr_at(`CDFS_OFS_UNC_ADDR0))
      d.unc_addr0 = i_wdata;
    if (wr_at(`CDFS_OFS_UNC_ADDR1))
      d.unc_addr1 = i_wdata;
    if (wr_at(`CDFS_OFS_UNC_SET0))
      d.unc_set0 = i_wdata;
    if (wr_at(`CDFS_OFS_UNC_SET1))
      d.unc_set1 = i_wdata;
    // key in bits 15:8, otherwise the write is dropped
    if (wr_at(`CDFS_OFS_ENTRY) && i_wdata[15:8] == `CDFS_KEY_ENTRY && !q.run)
    begin
      d.code_pe = i_wdata[0];
      d.data_pe = i_wdata[7];
    end
    if (wr_at(`CDFS_OFS_PROT) && i_wdata[15:8] == `CDFS_KEY_PROT)
      d.prot_off = i_wdata[0];
    if (wr_at(`CDFS_OFS_CLKNOTE) && i_wdata[15:8] == `CDFS_KEY_CLK)
      d.clk_mhz = i_wdata[7:0];
    if (wr_at(`CDFS_OFS_BCCTL))
      d.bc_on = i_wdata[0];
    if (wr_at(`CDFS_OFS_AVIRQ))
    begin
      d.cav_ie = i_wdata[0];
      d.dav_ie = i_wdata[1];
    end
    // write data buffer holds one word until the engine finishes
    if (wr_at(`CDFS_OFS_WDATA))
      d.buf_full = 1'b1;
    // status flags clear by writing zero over them
    if (wr_at(`CDFS_OFS_STATUS))
    begin
      d.perr = q.perr & i_wdata[`CDFS_BIT_PERR];
      d.eerr = q.eerr & i_wdata[`CDFS_BIT_EERR];
      d.ilgl = q.ilgl & i_wdata[`CDFS_BIT_ILGL];
      d.weperr = q.weperr & i_wdata[`CDFS_BIT_WEPERR];
    end
    if (wr_at(`CDFS_OFS_AVSTAT))
    begin
      d.cav = q.cav & i_wdata[0];
      d.dav = q.dav & i_wdata[1];
    end
    if (i_code_bad_access)
      d.cav = 1'b1;
    if (i_data_bad_access)
      d.dav = 1'b1;
    if (wr_at(`CDFS_OFS_CMD) && !q.run)
    begin
      if (!cmd_ok)
        d.ilgl = 1'b1;
      else if (q.prot_off == 1'b0 && new_cmd != CDFS_CMD_BLANK)
        d.weperr = 1'b1;
      else
      begin
        d.run = 1'b1;
        d.start = 1'b1;
        d.cmd = new_cmd;
      end
    end
    else if (wr_at(`CDFS_OFS_CMD))
      d.ilgl = 1'b1;
    if (op.done)
    begin
      d.run = 1'b0;
      // a word written in the finishing cycle keeps the buffer full
      d.buf_full = wr_at(`CDFS_OFS_WDATA);
      if (q.cmd == CDFS_CMD_BLANK)
        d.bc_res = ~op.blank;
      if (op.fail && q.cmd == CDFS_CMD_PROG)
        d.perr = 1'b1;
      if (op.fail && q.cmd == CDFS_CMD_ERASE)
        d.eerr = 1'b1;
    end
    // no suspend command exists, so these stay clear
    d.psusp = 1'b0;
    d.esusp = 1'b0;
    // interrupt path is independent of the sequencer busy state
    d.irq = (d.cav & d.cav_ie) | (d.dav & d.dav_ie);
    d.rdata = 32'h0;
    if (i_rd)
    begin
      case (i_addr)
        `CDFS_OFS_STATUS:
        begin
          d.rdata[`CDFS_BIT_PSUSP] = q.psusp;
          d.rdata[`CDFS_BIT_ESUSP] = q.esusp;
          d.rdata[`CDFS_BIT_SUSP_RDY] = q.run && q.cmd != CDFS_CMD_BLANK;
          d.rdata[`CDFS_BIT_PERR] = q.perr;
          d.rdata[`CDFS_BIT_EERR] = q.eerr;
          d.rdata[`CDFS_BIT_ILGL] = q.ilgl;
          d.rdata[`CDFS_BIT_RDY] = ~q.run;
          d.rdata[`CDFS_BIT_WEPERR] = q.weperr;
          d.rdata[`CDFS_BIT_BUF_FULL] = q.buf_full;
        end
        `CDFS_OFS_ENTRY: d.rdata = {24'h0, q.data_pe, 6'h0, q.code_pe};
        `CDFS_OFS_PROT: d.rdata = {31'h0, q.prot_off};
        `CDFS_OFS_SADDR: d.rdata = q.saddr;
        `CDFS_OFS_EADDR: d.rdata = q.eaddr;
        `CDFS_OFS_BCCTL: d.rdata = {31'h0, q.bc_on};
        `CDFS_OFS_BCSTAT: d.rdata = {24'h0, 7'h0, q.bc_res};
        `CDFS_OFS_PSADDR: d.rdata = q.psaddr;
        `CDFS_OFS_CLKNOTE: d.rdata = {24'h0, q.clk_mhz};
        `CDFS_OFS_AVSTAT: d.rdata = {30'h0, q.dav, q.cav};
        `CDFS_OFS_AVIRQ: d.rdata = {30'h0, q.dav_ie, q.cav_ie};
        `CDFS_OFS_CMD: d.rdata = {28'h0, q.cmd};
        `CDFS_OFS_UID0: d.rdata = UID0;
        `CDFS_OFS_UID1: d.rdata = UID1;
        `CDFS_OFS_UID2: d.rdata = UID2;
        `CDFS_OFS_UNC_ADDR0: d.rdata = q.unc_addr0;
        `CDFS_OFS_UNC_ADDR1: d.rdata = q.unc_addr1;
        `CDFS_OFS_UNC_SET0: d.rdata = q.unc_set0;
        `CDFS_OFS_UNC_SET1: d.rdata = q.unc_set1;
        default: d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      q <= '0;
      q.clk_mhz <= `CDFS_CLK_RST;
    end
    else
      q <= d;
  end

  // ------------------------------------------------------------
  // engine
  // ------------------------------------------------------------
  assign op.start = q.start;
  assign op.cmd = q.cmd;
  assign op.is_data = in_data(q.saddr);
  assign op.saddr = q.saddr;
  assign op.eaddr = q.eaddr;

  cdfs_engine #(
    .OP_CYC(OP_CYC)
  ) cdfs_engine_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_cell_erased(i_cell_erased),
    .op(op)
  );

  assign o_rdata = q.rdata;
  assign o_access_irq = q.irq;
  assign o_busy = q.run;
endmodule : cdfs_top

// ===== testbench/cdfs_props.sv
// port checker for the flash sequencer top
`timescale 1ns/1ps
`include "cdfs_defines.svh"
module cdfs_props #(
  parameter logic [31:0] UID0 = 32'h0000_0000,
  parameter logic [31:0] UID1 = 32'h0000_0000,
  parameter logic [31:0] UID2 = 32'h0000_0000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire cdfs_pkg::cdfs_word_t o_rdata,
  // events and status
  input wire logic i_code_bad_access,
  input wire logic i_data_bad_access,
  input wire logic o_access_irq,
  input wire logic o_busy
);
  import cdfs_pkg::*;
  logic irq_cause;
  logic st_rd;
  assign irq_cause = i_code_bad_access | i_data_bad_access | (i_wr & (i_addr == `CDFS_OFS_AVIRQ));
  assign st_rd = i_rd & (i_addr == `CDFS_OFS_STATUS);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  ready_bit_a: assert property ($past(st_rd) |-> o_rdata[15] == !$past(o_busy))
    else $error("ready bit disagrees with busy");
  suspend_zero_a: assert property ($past(st_rd) |-> o_rdata[9:8] == 2'h0)
    else $error("suspend flag set without suspend");
  op_error_a: assert property ($past(st_rd) |-> o_rdata[13:12] == 2'h0)
    else $error("operation error flag set");
  blank_width_a: assert property ($past(i_rd && i_addr == `CDFS_OFS_BCSTAT)
    |-> o_rdata[31:8] == 24'h0)
    else $error("blank status wider than 8 bits");
  uid_value_a: assert property ($past(i_rd) |->
    ($past(i_addr) != `CDFS_OFS_UID0 || o_rdata == UID0)
    && ($past(i_addr) != `CDFS_OFS_UID1 || o_rdata == UID1)
    && ($past(i_addr) != `CDFS_OFS_UID2 || o_rdata == UID2))
    else $error("unique id word wrong");
  irq_cause_a: assert property ($rose(o_access_irq) |-> $past(irq_cause) || $past(irq_cause, 2))
    else $error("interrupt without cause");
  busy_start_a: assert property ($rose(o_busy) |-> $past(i_wr && i_addr == `CDFS_OFS_CMD))
    else $error("busy without command write");
  busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*3])
    else $error("busy dropped too early");
  busy_end_a: assert property ($rose(o_busy) |-> ##[1:1000] !o_busy)
    else $error("busy never ended");
endmodule : cdfs_props

// ===== testbench/tb_top.sv
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "cdfs_defines.svh"
module tb_top;
  import cdfs_pkg::*;
  localparam logic [31:0] U0 = 32'hC0DE_0001; // arbitrary value
  localparam logic [31:0] U1 = 32'hC0DE_0002; // arbitrary value
  localparam logic [31:0] U2 = 32'hC0DE_0003; // arbitrary value
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  cdfs_word_t i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cell_erased = 1'b1;
  logic i_code_bad_access = 1'b0;
  logic i_data_bad_access = 1'b0;
  cdfs_word_t o_rdata;
  logic o_access_irq;
  logic o_busy;
  int fail_count = 0;
  int samples_checked = 0;
  cdfs_word_t d;
  cdfs_word_t st;
  always #5 i_clk = ~i_clk;
  // short op time keeps multi-unit commands fast
  cdfs_top #(.UID0(U0), .UID1(U1), .UID2(U2), .OP_CYC(2)) cdfs_top_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cell_erased(i_cell_erased),
    .i_code_bad_access(i_code_bad_access), .i_data_bad_access(i_data_bad_access),
    .o_access_irq(o_access_irq), .o_busy(o_busy));
  // ----
  // bus and compare helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb
  task automatic wr(input logic [7:0] a, input cdfs_word_t v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  task automatic clr();
    wr(`CDFS_OFS_STATUS, 32'h0);
  endtask : clr
  // st holds status once the command has settled
  task automatic cmd(input logic [3:0] c, input logic ok);
    int n;
    wr(`CDFS_OFS_CMD, {28'h0, c});
    #1 chb(o_busy, ok);
    rd(`CDFS_OFS_STATUS);
    chb(d[15], !ok);
    n = 0;
    while (o_busy !== 1'b0 && n < 3000)
    begin
      @(posedge i_clk);
      n++;
    end
    #1 chb(o_busy, 1'b0);
    rd(`CDFS_OFS_STATUS);
    st = d;
  endtask : cmd
  task automatic pulse(input logic code);
    @(posedge i_clk);
    i_code_bad_access <= code;
    i_data_bad_access <= !code;
    @(posedge i_clk);
    i_code_bad_access <= 1'b0;
    i_data_bad_access <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : pulse
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rd(`CDFS_OFS_CLKNOTE);
    chk({24'h0, d[7:0]}, 32'h3C);
    wr(`CDFS_OFS_CLKNOTE, 32'h0000_0064);
    rd(`CDFS_OFS_CLKNOTE);
    chk({24'h0, d[7:0]}, 32'h3C);
    wr(`CDFS_OFS_CLKNOTE, 32'h0000_1E64);
    rd(`CDFS_OFS_CLKNOTE);
    chk({24'h0, d[7:0]}, 32'h64);
    wr(`CDFS_OFS_UID0, 32'h0);
    rd(`CDFS_OFS_UID0);
    chk(d, U0);
    rd(`CDFS_OFS_UID1);
    chk(d, U1);
    rd(`CDFS_OFS_UID2);
    chk(d, U2);
    wr(`CDFS_OFS_UNC_ADDR0, 32'h0000_1230);
    wr(`CDFS_OFS_UNC_SET1, 32'h0000_0001);
    rd(`CDFS_OFS_UNC_ADDR0);
    chk(d, 32'h0000_1230);
    rd(`CDFS_OFS_UNC_SET1);
    chk(d, 32'h0000_0001);
    rd(8'h7C);
    chk(d, 32'h0);
    wr(`CDFS_OFS_ENTRY, 32'h0000_0001);
    rd(`CDFS_OFS_ENTRY);
    chb(d[0], 1'b0);
  endtask : t_regs
  task automatic t_data();
    wr(`CDFS_OFS_ENTRY, 32'h0000_AA80);
    wr(`CDFS_OFS_PROT, 32'h0000_5501);
    wr(`CDFS_OFS_SADDR, 32'h0010_0000);
    wr(`CDFS_OFS_EADDR, 32'h0010_0004);
    cmd(4'h1, 1'b0);
    chb(st[14], 1'b1);
    clr();
    wr(`CDFS_OFS_EADDR, 32'h0010_0003);
    wr(`CDFS_OFS_PSADDR, 32'h0010_0000);
    rd(`CDFS_OFS_PSADDR);
    chk(d, 32'h0010_0000);
    wr(`CDFS_OFS_WDATA, 32'hA5A5_5A5A);
    rd(`CDFS_OFS_STATUS);
    chb(d[10], 1'b1);
    cmd(4'h1, 1'b1);
    chb(st[14], 1'b0);
    chb(st[10], 1'b0);
    wr(`CDFS_OFS_EADDR, 32'h0010_07FF);
    cmd(4'h2, 1'b0);
    chb(st[14], 1'b1);
    clr();
    wr(`CDFS_OFS_EADDR, 32'h0010_0FFF);
    cmd(4'h2, 1'b1);
    chb(st[14], 1'b0);
    wr(`CDFS_OFS_PROT, 32'h0000_5500);
    cmd(4'h2, 1'b0);
    chb(st[7], 1'b1);
    clr();
  endtask : t_data
  task automatic t_code();
    wr(`CDFS_OFS_ENTRY, 32'h0000_AA01);
    rd(`CDFS_OFS_ENTRY);
    chb(d[0], 1'b1);
    wr(`CDFS_OFS_PROT, 32'h0000_5501);
    wr(`CDFS_OFS_SADDR, 32'hFF00_0000);
    wr(`CDFS_OFS_EADDR, 32'hFF00_0003);
    cmd(4'h3, 1'b0);
    chb(st[14], 1'b1);
    clr();
    wr(`CDFS_OFS_EADDR, 32'hFF00_007F);
    cmd(4'h1, 1'b0);
    chb(st[14], 1'b1);
    clr();
    wr(`CDFS_OFS_EADDR, 32'hFF00_00FF);
    wr(`CDFS_OFS_WDATA, 32'h1234_5678);
    cmd(4'h1, 1'b1);
    chb(st[14], 1'b0);
  endtask : t_code
  task automatic t_blank();
    wr(`CDFS_OFS_ENTRY, 32'h0000_AA80);
    wr(`CDFS_OFS_SADDR, 32'h0010_0000);
    wr(`CDFS_OFS_EADDR, 32'h0010_0003);
    cmd(4'h3, 1'b1);
    rd(`CDFS_OFS_BCSTAT);
    chb(d[0], 1'b0);
    i_cell_erased <= 1'b0;
    wr(`CDFS_OFS_EADDR, 32'h0010_000F);
    cmd(4'h3, 1'b1);
    rd(`CDFS_OFS_BCSTAT);
    chb(d[0], 1'b1);
    i_cell_erased <= 1'b1;
    wr(`CDFS_OFS_EADDR, 32'h0010_0012);
    cmd(4'h3, 1'b0);
    chb(st[14], 1'b1);
    clr();
    wr(`CDFS_OFS_EADDR, 32'h0010_8003);
    cmd(4'h3, 1'b0);
    chb(st[14], 1'b1);
    clr();
  endtask : t_blank
  task automatic t_irq();
    wr(`CDFS_OFS_AVIRQ, 32'h0);
    pulse(1'b1);
    chb(o_access_irq, 1'b0);
    rd(`CDFS_OFS_AVSTAT);
    st = d;
    chk(st, 32'h0000_0001);
    wr(`CDFS_OFS_AVIRQ, 32'hFFFF_FFFF);
    repeat (3) @(posedge i_clk);
    #1 chb(o_access_irq, 1'b1);
    wr(`CDFS_OFS_AVSTAT, 32'h0);
    repeat (3) @(posedge i_clk);
    #1 chb(o_access_irq, 1'b0);
    pulse(1'b0);
    chb(o_access_irq, 1'b1);
    rd(`CDFS_OFS_AVSTAT);
    chk(d, 32'h0000_0002);
    wr(`CDFS_OFS_AVSTAT, 32'h0);
  endtask : t_irq
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_data();
    t_code();
    t_blank();
    t_irq();
    finish_test();
  end
  initial
  begin
    #300000;
    fail_count++;
    finish_test();
  end
endmodule : tb_top
bind cdfs_top cdfs_props #(.UID0(UID0), .UID1(UID1), .UID2(UID2)) cdfs_props_inst (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_code_bad_access(i_code_bad_access),
  .i_data_bad_access(i_data_bad_access), .o_access_irq(o_access_irq), .o_busy(o_busy));
